// ---- core/sram_host_pkg.sv ----
// Purpose: Constants and carrier types for the static RAM host controller.
// Assumes: 40 MHz ref_clk; RAM timing at either 5 V or 3 V grade.
// Notes: All pin-facing timing counts derive from ns figures here; the recovery count derives from ms and MHz.
// How it works
// [RULE1] RAM holds 2048 bytes, 11-bit address, 8-bit two-way data.
// [RULE2] Chip select high puts RAM in standby, data floats, inputs ignored.
// [RULE3] Write strobe stays high through reads; select+drive low gives data.
// [RULE4] During writes output drive may be either level; high keeps bus off.
// [RULE5] Write pulse is select and strobe both low, 75 ns or 190 ns least.
// [RULE6] Data is stored at the first rising of select or strobe.
// [RULE7] Select falling with or after strobe low keeps RAM outputs off.
// [RULE8] Select rising before or with strobe keeps RAM outputs off.
// [RULE9] Read data valid 100 ns or 250 ns after stable address.
// [RULE10] Old data held 5 ns or 15 ns after an address change.
// [RULE11] RAM releases bus within 35 ns or 100 ns of deselect.
// [RULE12] Host deselects before supply drop, waits 2 ms after restore.
// [RULE13] Host frees its data drivers before read, drive high when writing.
package sram_host_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 25;
  // Least times round up, in ns
  localparam int WP_5V_NS = 75;
  localparam int WP_3V_NS = 190;
  localparam int ACC_5V_NS = 100;
  localparam int ACC_3V_NS = 250;
  localparam int OD_5V_NS = 35;
  localparam int OD_3V_NS = 100;
  localparam int DS_5V_NS = 40;
  localparam int DS_3V_NS = 100;
  localparam int WR_5V_NS = 10;
  localparam int WR_3V_NS = 25;
  localparam int RECOVERY_MS = 2;
  localparam int CLK_MHZ = 40;
  localparam int CNT_W = 17;
  localparam int WP_5V_CYC = (WP_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_3V_CYC = (WP_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_5V_CYC = (ACC_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_3V_CYC = (ACC_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OD_5V_CYC = (OD_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OD_3V_CYC = (OD_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_5V_CYC = (WR_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_3V_CYC = (WR_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = RECOVERY_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic we;                 // 1 write, 0 read
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
  } ram_ctl_t;

  typedef enum logic [5:0] {
    ST_RECOVER = 6'h01,
    ST_IDLE    = 6'h02,
    ST_READ    = 6'h04,
    ST_WRITE   = 6'h08,
    ST_RELEASE = 6'h10,
    ST_HOLD    = 6'h20
  } state_t;
endpackage

// ---- core/sram_host.sv ----
// Purpose: Host controller driving a 2k x 8 asynchronous static RAM.
// Assumes: ref_clk 40 MHz; pin inputs synchronous; one request at a time.
// Notes: Grade input picks 5 V or 3 V timing; retain_req parks the RAM.
`timescale 1ns/1ps
module sram_host #(
  parameter int RECOVERY_CYCLES = sram_host_pkg::RECOVERY_CYC
) (
  input wire logic ref_clk,                           // 40 MHz clock
  input wire logic rstn,                              // Sync reset, low
  input wire logic low_volt,                          // 1 selects 3 V timing
  input wire logic retain_req,                        // Hold for retention
  input wire logic req_valid,                         // Request strobe
  input wire sram_host_pkg::host_req_t req,           // Request fields
  output logic req_ready,                             // Ready for request
  output logic rd_valid,                              // Read data pulse
  output logic [sram_host_pkg::DATA_W-1:0] rd_data,   // Read data
  output logic retain_ok,                             // Safe to cut supply
  output sram_host_pkg::ram_ctl_t ram_ctl,            // Select, drive, etc.
  input wire logic [sram_host_pkg::DATA_W-1:0] data_lines_i, // Bus in
  output logic [sram_host_pkg::DATA_W-1:0] data_lines_o,     // Bus out
  output logic data_lines_oe                          // Bus drive enable
);
  import sram_host_pkg::*;

  // ------------------------------------------------------------
  // Timing selection
  // ------------------------------------------------------------
  logic [CNT_W-1:0] acc_cyc, wp_cyc, od_cyc, wr_cyc;
  always_comb begin
    acc_cyc = low_volt ? CNT_W'(ACC_3V_CYC) : CNT_W'(ACC_5V_CYC); // [RULE9]
    wp_cyc = low_volt ? CNT_W'(WP_3V_CYC) : CNT_W'(WP_5V_CYC);    // [RULE5]
    od_cyc = low_volt ? CNT_W'(OD_3V_CYC) : CNT_W'(OD_5V_CYC);    // [RULE11]
    wr_cyc = low_volt ? CNT_W'(WR_3V_CYC) : CNT_W'(WR_5V_CYC);
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic was_read_q;
  wire cnt_done = (cnt_q == '0);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= ST_RECOVER;
      cnt_q <= CNT_W'(RECOVERY_CYCLES); // [RULE12]
      was_read_q <= 1'b0;
    end else begin
      if (!cnt_done) cnt_q <= cnt_q - 1'b1;
      case (state_q)
        ST_RECOVER: begin
          // Any access before recovery ends could corrupt the array
          if (retain_req) begin
            cnt_q <= CNT_W'(RECOVERY_CYCLES); // [RULE12]
          end else if (cnt_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (retain_req) begin
            state_q <= ST_RECOVER;
            cnt_q <= CNT_W'(RECOVERY_CYCLES); // [RULE12]
          end else if (req_valid) begin
            state_q <= req.we ? ST_WRITE : ST_READ;
            was_read_q <= !req.we;
            // Read waits full access time; write the pulse width
            cnt_q <= req.we ? wp_cyc - 1'b1 : acc_cyc - 1'b1;
          end
        end
        ST_READ: if (cnt_done) begin // [RULE9]
          state_q <= ST_RELEASE;
          cnt_q <= od_cyc - 1'b1;
        end
        ST_WRITE: if (cnt_done) begin // [RULE5]
          state_q <= ST_HOLD;
          cnt_q <= wr_cyc - 1'b1;
        end
        ST_RELEASE: if (cnt_done) begin // [RULE11]
          state_q <= ST_IDLE;
        end
        ST_HOLD: if (cnt_done) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_RECOVER;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ram_ctl.cs_n <= 1'b1; // [RULE2]
      ram_ctl.oe_n <= 1'b1;
      ram_ctl.we_n <= 1'b1;
      ram_ctl.addr <= '0;
      data_lines_o <= '0;
      data_lines_oe <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req_valid && !retain_req) begin
            ram_ctl.addr <= req.addr; // [RULE1]
            ram_ctl.cs_n <= 1'b0;
            ram_ctl.we_n <= !req.we;  // [RULE3]
            // On a write, select and strobe fall together so RAM stays off bus
            ram_ctl.oe_n <= req.we;   // [RULE4] [RULE7] [RULE13]
            data_lines_o <= req.wdata;
            data_lines_oe <= req.we;  // [RULE13]
          end
        end
        ST_WRITE: begin
          if (cnt_done) begin
            // Strobe rises first; data and address held past it
            ram_ctl.we_n <= 1'b1; // [RULE6] [RULE8]
          end
        end
        ST_HOLD: begin
          if (cnt_done) begin
            ram_ctl.cs_n <= 1'b1;
            data_lines_oe <= 1'b0;
          end
        end
        ST_READ: begin
          if (cnt_done) begin
            ram_ctl.oe_n <= 1'b1;
            ram_ctl.cs_n <= 1'b1; // [RULE2]
          end
        end
        default: begin
          ram_ctl.cs_n <= 1'b1; // [RULE12]
          ram_ctl.oe_n <= 1'b1;
          ram_ctl.we_n <= 1'b1;
          data_lines_oe <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // User side
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (state_q == ST_READ && cnt_done) begin
        rd_data <= data_lines_i; // [RULE9] [RULE10]
        rd_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      req_ready <= 1'b0;
      retain_ok <= 1'b0;
    end else begin
      req_ready <= (state_q == ST_IDLE) && !req_valid && !retain_req;
      retain_ok <= (state_q == ST_RECOVER) && retain_req; // [RULE12]
    end
  end
  // req_ready is a hint; req_valid is taken in idle regardless
  wire unused_ok = was_read_q;
endmodule

// ---- testbench/sram_host_monitor.sv ----
// Purpose: Pin-level checks for the static RAM host controller.
// Assumes: Sees only the ports of sram_host.
// Notes: 5 V and 3 V pulse lengths are checked separately.
`timescale 1ns/1ps
module sram_host_monitor
  import sram_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic low_volt,
  input wire logic retain_ok,
  input wire ram_ctl_t ram_ctl,
  input wire logic [DATA_W-1:0] data_lines_o,
  input wire logic data_lines_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_ws; !ram_ctl.we_n |-> !ram_ctl.cs_n && ram_ctl.oe_n; endproperty
  a_ws: assert property (p_ws) else $error("strobe low off a write");
  property p_rd; !ram_ctl.oe_n |-> ram_ctl.we_n && !data_lines_oe; endproperty
  a_rd: assert property (p_rd) else $error("read with strobe or bus");
  property p_wp5; $fell(ram_ctl.we_n) && !low_volt |-> (!ram_ctl.we_n)[*3];
  endproperty
  a_wp5: assert property (p_wp5) else $error("short 5 V pulse");
  property p_wp3; $fell(ram_ctl.we_n) && low_volt |-> (!ram_ctl.we_n)[*8];
  endproperty
  a_wp3: assert property (p_wp3) else $error("short 3 V pulse");
  property p_wd; !ram_ctl.we_n |=> data_lines_oe && $stable(data_lines_o)
    && $stable(ram_ctl.addr); endproperty
  a_wd: assert property (p_wd) else $error("write data moved");
  property p_ac5; $fell(ram_ctl.oe_n) && !low_volt |-> (!ram_ctl.oe_n)[*4];
  endproperty
  a_ac5: assert property (p_ac5) else $error("short 5 V read");
  property p_ac3; $fell(ram_ctl.oe_n) && low_volt |-> (!ram_ctl.oe_n)[*8]
    ##1 (!ram_ctl.oe_n)[*2]; endproperty
  a_ac3: assert property (p_ac3) else $error("short 3 V read");
  property p_ret; retain_ok |-> ram_ctl.cs_n; endproperty
  a_ret: assert property (p_ret) else $error("selected in retain");
endmodule
bind sram_host sram_host_monitor mon (.ref_clk(ref_clk), .rstn(rstn),
  .low_volt(low_volt), .retain_ok(retain_ok), .ram_ctl(ram_ctl),
  .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));

// ---- testbench/sram_model.sv ----
// Purpose: Behavioural 2k x 8 asynchronous static RAM.
// Assumes: Access time is taken just inside the limit.
// Notes: A floating bus shows the inverse of the addressed byte.
`timescale 1ns/1ps
module sram_model
  import sram_host_pkg::*;
(
  input wire logic low_volt,
  input wire ram_ctl_t ctl,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout,
  output logic drive
);
  logic [DATA_W-1:0] mem [0:2047];
  logic rd_en;
  logic ready = 1'b0;
  logic wr_on = 1'b0;
  // Drives only when selected, driven and not writing
  assign rd_en = !ctl.cs_n && !ctl.oe_n && ctl.we_n;
  assign drive = ready && rd_en;
  assign dout = drive ? mem[ctl.addr] : ~mem[ctl.addr];
  always @(rd_en, ctl.addr) begin
    ready = 1'b0;
    if (rd_en) ready <= #(low_volt ? ACC_3V_NS-1 : ACC_5V_NS-1) 1'b1;
  end
  // Byte lands when the first of select or strobe rises
  always @(ctl.cs_n, ctl.we_n) begin
    if (wr_on && (ctl.cs_n || ctl.we_n)) mem[ctl.addr] = din;
    wr_on = !ctl.cs_n && !ctl.we_n;
  end
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the static RAM host controller.
// Assumes: Recovery shortened to 20 cycles.
// Notes: Inputs change on the falling edge.
`timescale 1ns/1ps
module tb_top;
  import sram_host_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic low_volt = 1'b0;
  logic retain_req = 1'b0;
  logic req_valid = 1'b0;
  host_req_t req = '0;
  logic req_ready, rd_valid, retain_ok, data_lines_oe, ram_drive;
  logic [DATA_W-1:0] rd_data, data_lines_o, ram_q, bus;
  ram_ctl_t ram_ctl;
  int bad_count = 0;
  int checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  assign bus = data_lines_oe ? data_lines_o : ram_q;
  sram_host #(.RECOVERY_CYCLES(20)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .low_volt(low_volt), .retain_req(retain_req), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .retain_ok(retain_ok), .ram_ctl(ram_ctl),
    .data_lines_i(bus), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe));
  sram_model ram (.low_volt(low_volt), .ctl(ram_ctl), .din(bus),
    .dout(ram_q), .drive(ram_drive));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge ref_clk) if (data_lines_oe && ram_drive) chk(1, 0);
  task automatic wait_ready;
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 200) begin
        chk(0, 1);
        tally_and_finish;
      end
    end
  endtask
  task automatic access(input logic we, input logic [10:0] a,
    input logic [7:0] d);
    int n;
    wait_ready;
    req = {we, a, d};
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 0;
    if (!we) begin
      while (rd_valid !== 1'b1 && n < 40) begin
        @(negedge ref_clk);
        n++;
      end
      chk(rd_data, d);
      // rd_valid shows at the negedge after the access count ends
      chk(n[15:0], low_volt ? 16'(ACC_3V_CYC) : 16'(ACC_5V_CYC));
    end
  endtask
  task automatic s_rw(input logic lv);
    logic [7:0] d;
    d = 8'hA5 ^ {8{lv}};
    wait_ready;
    low_volt = lv;
    access(1'b1, 11'h000, d);
    access(1'b1, 11'h7FF, ~d);
    access(1'b0, 11'h000, d);
    access(1'b0, 11'h7FF, ~d);
  endtask
  task automatic s_retain;
    wait_ready;
    retain_req = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(retain_ok, 1);
    chk(req_ready, 0);
    retain_req = 1'b0;
    access(1'b0, 11'h7FF, 8'hA5);
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    s_rw(1'b0);
    s_rw(1'b1);
    s_retain;
    tally_and_finish;
  end
endmodule
